// ---- sbs_abs_if.sv ----
`default_nettype none

interface sbs_abs_if;
    logic req_pin;
    logic ser_byte;
    logic start;
    logic wait_serial;
    logic busy;
    logic done;

    modport seq (
        input req_pin,
        input ser_byte,
        output start,
        output wait_serial,
        output busy,
        output done
    );

    modport core (
        output req_pin,
        output ser_byte,
        input start,
        input wait_serial,
        input busy,
        input done
    );
endinterface

`default_nettype wire

// ---- sbs_abs_seq.sv ----
`include "sbs_params.svh"
`default_nettype none

module sbs_abs_seq #(
    parameter int unsigned DELAY_CYC = 10000000,
    parameter int unsigned SETTLE_CYC = 2500000
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    sbs_abs_if.seq bus
);

    sbs_pkg::sbs_abs_state_t s_reg;
    sbs_pkg::sbs_abs_state_t s_next;
    logic rise;

    // ----------------------------------------------------------------
    // request pin sync and sequence
    // ----------------------------------------------------------------
    // edge taken from stages two and three only
    assign rise = s_reg.sync[1] & ~s_reg.sync[2];

    always_comb begin
        s_next = s_reg;
        s_next.sync = {s_reg.sync[1:0], bus.req_pin};
        s_next.start = 1'b0;
        s_next.done = 1'b0;
        case (s_reg.st)
            sbs_pkg::SBS_ABS_IDLE: begin
                s_next.cnt = '0;
            end
            sbs_pkg::SBS_ABS_DELAY: begin
                s_next.cnt = s_reg.cnt + `SBS_CNT_W'(1);
                if (s_reg.cnt == `SBS_CNT_W'(DELAY_CYC - 1)) begin
                    s_next.st = sbs_pkg::SBS_ABS_SERIAL;
                    s_next.cnt = '0;
                    s_next.got_byte = 1'b0;
                    s_next.start = 1'b1;
                end
            end
            sbs_pkg::SBS_ABS_SERIAL: begin
                // settle window restarts on every byte
                if (bus.ser_byte) begin
                    s_next.got_byte = 1'b1;
                    s_next.cnt = '0;
                end else if (s_reg.got_byte) begin
                    s_next.cnt = s_reg.cnt + `SBS_CNT_W'(1);
                    if (s_reg.cnt == `SBS_CNT_W'(SETTLE_CYC - 1)) begin
                        s_next.st = sbs_pkg::SBS_ABS_IDLE;
                        s_next.done = 1'b1;
                    end
                end
            end
            default: begin
                s_next.st = sbs_pkg::SBS_ABS_IDLE;
            end
        endcase
        // every low-to-high edge restarts the output, even mid-sequence
        if (rise) begin
            s_next.st = sbs_pkg::SBS_ABS_DELAY;
            s_next.cnt = '0;
            s_next.start = 1'b0;
            s_next.done = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.start = s_reg.start;
    assign bus.done = s_reg.done;
    assign bus.wait_serial = (s_reg.st == sbs_pkg::SBS_ABS_SERIAL);
    assign bus.busy = (s_reg.st != sbs_pkg::SBS_ABS_IDLE);

endmodule

`default_nettype wire

// ---- sbs_core.sv ----
`include "sbs_params.svh"
`default_nettype none

module sbs_core #(
    parameter int unsigned TICK_CYC = `SBS_TICK_MS * (`SBS_CLK_HZ / 1000),
    parameter int unsigned ABS_DELAY_CYC = `SBS_ABS_DELAY_MS * (`SBS_CLK_HZ / 1000),
    parameter int unsigned ABS_SETTLE_CYC = `SBS_ABS_SETTLE_MS * (`SBS_CLK_HZ / 1000),
    parameter logic [15:0] MOTOR_MAX_RPM = `SBS_MAXRPM_DEF
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // avalon-mm slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    // drive pins and internal drive logic
    input wire logic servo_on_i,
    input wire logic main_pwr_ok_i,
    input wire logic ctrl_pwr_ok_i,
    input wire logic alarm_i,
    input wire logic signed [15:0] motor_speed_i,
    input wire logic turn_inc_i,
    input wire logic turn_dec_i,
    input wire logic axis_a_absolute_request_i,
    input wire logic axis_b_absolute_request_i,
    input wire logic [1:0] abs_byte_sent_i,
    output logic holding_brake_output_o,
    output logic rotation_detect_output_o,
    output logic [`SBS_N_TERM-1:0] out_term_o,
    output logic motor_energize_o,
    output logic decel_stop_o,
    output logic panel_off_o,
    output logic [15:0] multi_turn_o,
    output logic [1:0] abs_start_o,
    output logic [1:0] abs_wait_serial_o
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // speed magnitude; -32768 fits as unsigned 32768
    function automatic logic [15:0] sbs_mag(input logic signed [15:0] v);
        logic [15:0] r;
        r = v[15] ? 16'(-v) : 16'(v);
        return r;
    endfunction

    // one-hot decode of a terminal map field, 0 means unmapped
    function automatic logic [`SBS_N_TERM-1:0] sbs_term_sel(input logic [2:0] f);
        logic [`SBS_N_TERM-1:0] r;
        r = '0;
        for (int i = 0; i < `SBS_N_TERM; i++) begin
            if (f == 3'(i + 1)) begin
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] sbs_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // absolute data request sequencers, one per axis
    // ----------------------------------------------------------------
    logic [1:0] req_pins;
    logic [1:0] ax_busy;
    logic [1:0] ax_done;
    logic [1:0] ax_start;
    logic [1:0] ax_wait;

    assign req_pins = {axis_b_absolute_request_i, axis_a_absolute_request_i};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_axis
            sbs_abs_if ax_if ();
            assign ax_if.req_pin = req_pins[g];
            assign ax_if.ser_byte = abs_byte_sent_i[g];
            assign ax_busy[g] = ax_if.busy;
            assign ax_done[g] = ax_if.done;
            assign ax_start[g] = ax_if.start;
            assign ax_wait[g] = ax_if.wait_serial;
            sbs_abs_seq #(
                .DELAY_CYC(ABS_DELAY_CYC),
                .SETTLE_CYC(ABS_SETTLE_CYC)
            ) u_seq (
                .core_clk_i(core_clk_i),
                .sys_rst_i(sys_rst_i),
                .bus(ax_if.seq)
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    sbs_pkg::sbs_core_state_t s_reg;
    sbs_pkg::sbs_core_state_t s_next;

    logic req;
    logic wr_take;
    logic rd_load;
    logic [15:0] spd_abs;
    logic [15:0] thr_lim;
    logic below;
    logic power_ok;
    logic eff_on;
    logic decel_sel;
    logic brake_n;
    logic rotation_detect_output_n;
    logic [31:0] wmerged;
    logic [31:0] rd_val;
    logic [`SBS_N_IRQ-1:0] ev;
    logic [`SBS_N_TERM-1:0] bk_sel;
    logic [`SBS_N_TERM-1:0] tg_sel;

    // ----------------------------------------------------------------
    // bus handshake: one wait cycle, then answer
    // ----------------------------------------------------------------
    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~s_reg.ack;
    assign wr_take = avs_write_i & s_reg.ack;
    assign rd_load = avs_read_i & ~s_reg.ack;

    // ----------------------------------------------------------------
    // speed compare and stop cause
    // ----------------------------------------------------------------
    assign spd_abs = sbs_mag(motor_speed_i);
    // clamp so an oversized threshold behaves as the motor limit
    assign thr_lim = ({3'h0, s_reg.thr} > s_reg.max_rpm) ? s_reg.max_rpm
                                                         : {3'h0, s_reg.thr};
    assign below = spd_abs < thr_lim;
    assign power_ok = s_reg.mp_sync[1] & s_reg.cp_sync[1];
    // absolute output in progress blocks energizing regardless of servo on
    assign eff_on = s_reg.sv_sync[1] & power_ok & ~alarm_i & ~(|ax_busy);

    // alarm beats power loss, power loss beats the configured method
    always_comb begin
        if (alarm_i) begin
            decel_sel = 1'b0;
        end else if (!power_ok) begin
            decel_sel = 1'b1;
        end else begin
            decel_sel = ~s_reg.cfg[`SBS_CFG_STOP_BIT];
        end
    end

    // ----------------------------------------------------------------
    // output terminal mapping
    // ----------------------------------------------------------------
    assign bk_sel = sbs_term_sel(s_reg.cfg[`SBS_CFG_BK_LSB +: 3]);
    assign tg_sel = sbs_term_sel(s_reg.cfg[`SBS_CFG_TG_LSB +: 3]);
    assign rotation_detect_output_n = spd_abs >= `SBS_ROTATION_DETECT_OUTPUT_RPM;

    // ----------------------------------------------------------------
    // register read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        case (avs_address_i)
            `SBS_OFS_CFG: rd_val = s_reg.cfg;
            `SBS_OFS_THR: rd_val = {19'h0, s_reg.thr};
            `SBS_OFS_WAIT: rd_val = {25'h0, s_reg.wait_time};
            `SBS_OFS_MAXRPM: rd_val = {16'h0, s_reg.max_rpm};
            `SBS_OFS_STATUS: rd_val = {24'h0, ax_busy, s_reg.brk_st, s_reg.rotation_detect_output,
                                       s_reg.decel, s_reg.energize, s_reg.brake};
            `SBS_OFS_IRQ_STAT: rd_val = {28'h0, s_reg.irq_stat};
            `SBS_OFS_IRQ_MASK: rd_val = {28'h0, s_reg.irq_mask};
            `SBS_OFS_MTURN: rd_val = {16'h0, s_reg.mturn};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    assign wmerged = sbs_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        brake_n = s_reg.brake;
        ev = '0;
        // servo-on and power-good pins pass two stages before use
        s_next.sv_sync = {s_reg.sv_sync[0], servo_on_i};
        s_next.mp_sync = {s_reg.mp_sync[0], main_pwr_ok_i};
        s_next.cp_sync = {s_reg.cp_sync[0], ctrl_pwr_ok_i};

        // brake sequencing
        case (s_reg.brk_st)
            sbs_pkg::SBS_BRK_RUN: begin
                brake_n = 1'b0;
                s_next.tick_cnt = '0;
                s_next.wait_ticks = '0;
                if (!eff_on) begin
                    ev[`SBS_IRQ_ALARM] = alarm_i;
                    // a stop that is already slow engages at once
                    if (below) begin
                        s_next.brk_st = sbs_pkg::SBS_BRK_HELD;
                        brake_n = 1'b1;
                    end else begin
                        s_next.brk_st = sbs_pkg::SBS_BRK_STOP;
                    end
                end
            end
            sbs_pkg::SBS_BRK_STOP: begin
                s_next.tick_cnt = s_reg.tick_cnt + `SBS_CNT_W'(1);
                if (s_reg.tick_cnt == `SBS_CNT_W'(TICK_CYC - 1)) begin
                    s_next.tick_cnt = '0;
                    s_next.wait_ticks = s_reg.wait_ticks + 7'h01;
                end
                if (eff_on) begin
                    s_next.brk_st = sbs_pkg::SBS_BRK_RUN;
                    s_next.tick_cnt = '0;
                    s_next.wait_ticks = '0;
                end else if (below || (s_reg.wait_ticks >= s_reg.wait_time)) begin
                    s_next.brk_st = sbs_pkg::SBS_BRK_HELD;
                    brake_n = 1'b1;
                end
            end
            sbs_pkg::SBS_BRK_HELD: begin
                brake_n = 1'b1;
                if (eff_on) begin
                    s_next.brk_st = sbs_pkg::SBS_BRK_RUN;
                    brake_n = 1'b0;
                end
            end
            default: begin
                s_next.brk_st = sbs_pkg::SBS_BRK_HELD;
                brake_n = 1'b1;
            end
        endcase
        s_next.brake = brake_n;
        s_next.energize = (s_next.brk_st == sbs_pkg::SBS_BRK_RUN);
        // stop torque only while still turning; de-energized once stopped
        s_next.decel = (s_next.brk_st != sbs_pkg::SBS_BRK_RUN) & decel_sel
                       & (spd_abs != 16'h0000);
        s_next.rotation_detect_output = rotation_detect_output_n;
        // several functions on one terminal are ORed
        s_next.out_term = (bk_sel & {`SBS_N_TERM{brake_n}})
                        | (tg_sel & {`SBS_N_TERM{rotation_detect_output_n}});

        // multi-turn count, natural two's complement wrap
        if (turn_inc_i && !turn_dec_i) begin
            s_next.mturn = s_reg.mturn + 16'h0001;
            ev[`SBS_IRQ_WRAP] = (s_reg.mturn == 16'h7fff);
        end else if (turn_dec_i && !turn_inc_i) begin
            s_next.mturn = s_reg.mturn - 16'h0001;
            ev[`SBS_IRQ_WRAP] = (s_reg.mturn == 16'h8000);
        end

        ev[`SBS_IRQ_BRAKE] = brake_n & ~s_reg.brake;
        ev[`SBS_IRQ_ABS] = |ax_done;

        // bus access
        s_next.ack = req & ~s_reg.ack;
        if (rd_load) begin
            s_next.rdata = rd_val;
        end
        if (wr_take) begin
            case (avs_address_i)
                `SBS_OFS_CFG: begin
                    s_next.cfg = sbs_merge(s_reg.cfg, avs_writedata_i, avs_byteenable_i);
                end
                `SBS_OFS_THR: begin
                    // out-of-range writes clamp to the top of range
                    if (wmerged > {19'h0, `SBS_THR_MAX}) begin
                        s_next.thr = `SBS_THR_MAX;
                    end else begin
                        s_next.thr = wmerged[12:0];
                    end
                end
                `SBS_OFS_WAIT: begin
                    if (wmerged < {25'h0, `SBS_WAIT_MIN}) begin
                        s_next.wait_time = `SBS_WAIT_MIN;
                    end else if (wmerged > {25'h0, `SBS_WAIT_MAX}) begin
                        s_next.wait_time = `SBS_WAIT_MAX;
                    end else begin
                        s_next.wait_time = wmerged[6:0];
                    end
                end
                `SBS_OFS_MAXRPM: begin
                    // lanes merge into the stored limit; the upper half is dropped
                    s_next.max_rpm = 16'(sbs_merge({16'h0, s_reg.max_rpm}, avs_writedata_i,
                                                   avs_byteenable_i));
                end
                `SBS_OFS_IRQ_MASK: begin
                    s_next.irq_mask = wmerged[`SBS_N_IRQ-1:0];
                end
                default: begin
                end
            endcase
        end

        // sticky events: a new event wins over a write-one clear
        if (wr_take && (avs_address_i == `SBS_OFS_IRQ_STAT)) begin
            s_next.irq_stat = (s_reg.irq_stat & ~wmerged[`SBS_N_IRQ-1:0]) | ev;
        end else begin
            s_next.irq_stat = s_reg.irq_stat | ev;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            s_reg <= '0;
            s_reg.brk_st <= sbs_pkg::SBS_BRK_HELD;
            s_reg.brake <= 1'b1;
            s_reg.cfg <= `SBS_CFG_RST;
            s_reg.thr <= `SBS_THR_RST;
            s_reg.wait_time <= `SBS_WAIT_RST;
            s_reg.max_rpm <= MOTOR_MAX_RPM;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign avs_readdata_o = s_reg.rdata;
    assign irq_o = s_reg.irq;
    assign holding_brake_output_o = s_reg.brake;
    assign rotation_detect_output_o = s_reg.rotation_detect_output;
    assign out_term_o = s_reg.out_term;
    assign motor_energize_o = s_reg.energize;
    assign decel_stop_o = s_reg.decel;
    assign panel_off_o = ~s_reg.energize;
    assign multi_turn_o = s_reg.mturn;
    assign abs_start_o = ax_start;
    assign abs_wait_serial_o = ax_wait;

endmodule

`default_nettype wire

// ---- sbs_core_asserts.sv ----
`default_nettype none
// --------------------------
// sequencer checks
// --------------------------
module sbs_core_asserts (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic servo_on_i,
    input wire logic main_pwr_ok_i,
    input wire logic alarm_i,
    input wire logic turn_inc_i,
    input wire logic turn_dec_i,
    input wire logic holding_brake_output_o,
    input wire logic motor_energize_o,
    input wire logic decel_stop_o,
    input wire logic [15:0] multi_turn_o,
    input wire logic [1:0] abs_start_o,
    input wire logic [1:0] abs_wait_serial_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // wrap points of the turn count
    sequence s_up; turn_inc_i && !turn_dec_i && multi_turn_o == 16'h7fff; endsequence
    sequence s_dn; turn_dec_i && !turn_inc_i && multi_turn_o == 16'h8000; endsequence
    property p_up; s_up |=> multi_turn_o == 16'h8000; endproperty
    a_up: assert property (p_up) else $error("no wrap up");
    property p_dn; s_dn |=> multi_turn_o == 16'h7fff; endproperty
    a_dn: assert property (p_dn) else $error("no wrap down");
    // pins pass two sync flops, so four low cycles must have cut the drive
    property p_son; !servo_on_i [*4] |-> !motor_energize_o; endproperty
    a_son: assert property (p_son) else $error("servo off ignored");
    property p_pwr; !main_pwr_ok_i [*4] |-> !motor_energize_o; endproperty
    a_pwr: assert property (p_pwr) else $error("power loss ignored");
    property p_alm; alarm_i [*3] |-> !motor_energize_o && !decel_stop_o; endproperty
    a_alm: assert property (p_alm) else $error("alarm not coasting");
    property p_rel; motor_energize_o |-> !holding_brake_output_o; endproperty
    a_rel: assert property (p_rel) else $error("brake on while driven");
    property p_abs; |abs_wait_serial_o |-> !motor_energize_o; endproperty
    a_abs: assert property (p_abs) else $error("driven in abs window");
    sequence s_pls; abs_wait_serial_o[0] ##1 !abs_start_o[0]; endsequence
    property p_st; abs_start_o[0] |-> s_pls; endproperty
    a_st: assert property (p_st) else $error("bad start pulse");
endmodule
bind sbs_core sbs_core_asserts sbs_core_asserts_inst (.*);
`default_nettype wire

// ---- sbs_host_model.sv ----
`default_nettype none
// --------------------------
// host side of the absolute request
// --------------------------
module sbs_host_model #(
    parameter int HOLD = 30
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic ser_i,
    output logic req_o,
    output logic sent_o
);
    int cnt;
    int n;
    // request only after the power-up hold-off; eight bytes, four cycles apart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            n <= 0;
            req_o <= 1'b0;
            sent_o <= 1'b0;
        end else begin
            cnt <= (cnt < HOLD) ? cnt + 1 : cnt;
            req_o <= go_i && cnt >= HOLD;
            n <= ser_i ? n + 1 : 0;
            sent_o <= ser_i && n < 32 && n % 4 == 0;
        end
    end
endmodule
`default_nettype wire

// ---- sbs_params.svh ----
`ifndef SBS_PARAMS_SVH
`define SBS_PARAMS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define SBS_CLK_HZ 100000000
`define SBS_TICK_MS 10
`define SBS_ABS_DELAY_MS 100
`define SBS_ABS_SETTLE_MS 25
`define SBS_CNT_W 24

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SBS_OFS_CFG 6'h00
`define SBS_OFS_THR 6'h04
`define SBS_OFS_WAIT 6'h08
`define SBS_OFS_MAXRPM 6'h0c
`define SBS_OFS_STATUS 6'h10
`define SBS_OFS_IRQ_STAT 6'h14
`define SBS_OFS_IRQ_MASK 6'h18
`define SBS_OFS_MTURN 6'h1c

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SBS_CFG_STOP_BIT 0
`define SBS_CFG_BK_LSB 4
`define SBS_CFG_TG_LSB 8
`define SBS_CFG_RST 32'h0000_0000
`define SBS_THR_RST 13'h0064
`define SBS_THR_MAX 13'h1770
`define SBS_WAIT_RST 7'h32
`define SBS_WAIT_MIN 7'h0a
`define SBS_WAIT_MAX 7'h64
`define SBS_MAXRPM_DEF 16'h1388
`define SBS_ROTATION_DETECT_OUTPUT_RPM 16'h0014
`define SBS_N_TERM 6
`define SBS_N_IRQ 4
`define SBS_IRQ_BRAKE 0
`define SBS_IRQ_ALARM 1
`define SBS_IRQ_ABS 2
`define SBS_IRQ_WRAP 3

`endif

// ---- sbs_pkg.sv ----
`include "sbs_params.svh"
`default_nettype none

package sbs_pkg;

    // ----------------------------------------------------------------
    // brake and stop sequencing states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SBS_BRK_RUN  = 2'b00,
        SBS_BRK_STOP = 2'b01,
        SBS_BRK_HELD = 2'b10
    } sbs_brk_st_t;

    // absolute data request sequencing states
    typedef enum logic [1:0] {
        SBS_ABS_IDLE   = 2'b00,
        SBS_ABS_DELAY  = 2'b01,
        SBS_ABS_SERIAL = 2'b10
    } sbs_abs_st_t;

    typedef struct packed {
        logic [2:0] sync;
        sbs_abs_st_t st;
        logic got_byte;
        logic [`SBS_CNT_W-1:0] cnt;
        logic start;
        logic done;
    } sbs_abs_state_t;

    typedef struct packed {
        logic [1:0] sv_sync;
        logic [1:0] mp_sync;
        logic [1:0] cp_sync;
        sbs_brk_st_t brk_st;
        logic [`SBS_CNT_W-1:0] tick_cnt;
        logic [6:0] wait_ticks;
        logic brake;
        logic energize;
        logic decel;
        logic rotation_detect_output;
        logic [`SBS_N_TERM-1:0] out_term;
        logic [15:0] mturn;
        logic [31:0] cfg;
        logic [12:0] thr;
        logic [6:0] wait_time;
        logic [15:0] max_rpm;
        logic [`SBS_N_IRQ-1:0] irq_stat;
        logic [`SBS_N_IRQ-1:0] irq_mask;
        logic ack;
        logic [31:0] rdata;
        logic irq;
    } sbs_core_state_t;

endpackage

`default_nettype wire

// ---- test_servo_brake_stop_sequencer.sv ----
`default_nettype none
// --------------------------
// bench
// --------------------------
module test_servo_brake_stop_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic c = 0, r = 1, rd = 0, wr = 0, so = 0, mp = 1, cp = 1, al = 0, inc = 0, dec = 0, go = 0;
    logic [5:0] ad = 6'h00;
    logic [31:0] wd = 32'h0, q, rdat;
    logic signed [15:0] sp = 16'sh0000;
    logic wq, irq, bk, tg, en, dc, po, req, sent;
    logic [5:0] tm;
    logic [15:0] mt;
    logic [1:0] st, ws;
    int errors = 0;
    int cmp_count = 0;
    always #5 c = ~c;
    sbs_core #(.TICK_CYC(10), .ABS_DELAY_CYC(20), .ABS_SETTLE_CYC(10)) sbs_core_inst (
        .core_clk_i(c), .sys_rst_i(r), .avs_address_i(ad), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(q),
        .avs_waitrequest_o(wq), .irq_o(irq), .servo_on_i(so), .main_pwr_ok_i(mp),
        .ctrl_pwr_ok_i(cp), .alarm_i(al), .motor_speed_i(sp), .turn_inc_i(inc),
        .turn_dec_i(dec), .axis_a_absolute_request_i(req), .axis_b_absolute_request_i(1'b0),
        .abs_byte_sent_i({1'b0, sent}), .holding_brake_output_o(bk),
        .rotation_detect_output_o(tg), .out_term_o(tm), .motor_energize_o(en),
        .decel_stop_o(dc), .panel_off_o(po), .multi_turn_o(mt), .abs_start_o(st),
        .abs_wait_serial_o(ws));
    sbs_host_model sbs_host_model_inst (.clk_i(c), .rst_i(r), .go_i(go), .ser_i(ws[0]),
        .req_o(req), .sent_o(sent));
    // bus cycle: hold the request until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge c);
        rd <= !w;
        wr <= w;
        ad <= a;
        wd <= d;
        do @(posedge c); while (wq !== 1'b0);
        rdat = q;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge c);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog sized well above the turn-count sweep
    initial begin
        cyc(90000);
        errors++;
        stop_test;
    end
    initial begin
        cyc(5);
        r <= 1'b0;
        rchk(6'h04, 32'h64);
        rchk(6'h08, 32'h32);
        acc(1'b1, 6'h04, 32'h1b58);
        rchk(6'h04, 32'h1770);
        acc(1'b1, 6'h08, 32'h5);
        rchk(6'h08, 32'h0a);
        rchk(6'h3c, 32'h0);
        acc(1'b1, 6'h04, 32'h64);
        acc(1'b1, 6'h00, 32'h111);
        $display("test 1 done");
        sp <= 16'sh01f4;
        so <= 1'b1;
        cyc(10);
        chk(32'({en, bk, tm[0], tg}), 32'hb);
        so <= 1'b0;
        cyc(90);
        chk(32'({bk, dc}), 32'h0);
        cyc(30);
        chk(32'({bk, tm[0]}), 32'h3);
        $display("test 2 done");
        acc(1'b1, 6'h00, 32'h110);
        sp <= 16'shffce;
        so <= 1'b1;
        cyc(10);
        so <= 1'b0;
        cyc(8);
        chk(32'({bk, dc}), 32'h3);
        acc(1'b1, 6'h0c, 32'hc8);
        acc(1'b1, 6'h04, 32'h1770);
        sp <= 16'sh012c;
        so <= 1'b1;
        cyc(10);
        so <= 1'b0;
        cyc(8);
        chk(32'(bk), 32'h0);
        sp <= 16'sh0096;
        cyc(3);
        chk(32'(bk), 32'h1);
        $display("test 3 done");
        acc(1'b1, 6'h00, 32'h111);
        sp <= 16'sh01f4;
        so <= 1'b1;
        cyc(10);
        mp <= 1'b0;
        cyc(6);
        chk(32'({en, dc}), 32'h1);
        mp <= 1'b1;
        cp <= 1'b0;
        cyc(6);
        chk(32'({en, dc}), 32'h1);
        cp <= 1'b1;
        cyc(10);
        acc(1'b1, 6'h14, 32'hf);
        acc(1'b1, 6'h18, 32'h2);
        chk(32'(irq), 32'h0);
        al <= 1'b1;
        cyc(4);
        chk(32'({en, dc, irq}), 32'h1);
        cyc(110);
        chk(32'(bk), 32'h1);
        al <= 1'b0;
        acc(1'b1, 6'h14, 32'h2);
        cyc(2);
        chk(32'(irq), 32'h0);
        rchk(6'h14, 32'h1);
        $display("test 4 done");
        go <= 1'b1;
        cyc(20);
        chk(32'({en, po}), 32'h1);
        while (st[0] !== 1'b1) @(posedge c);
        chk(32'(ws[0]), 32'h1);
        cyc(80);
        chk(32'({en, ws[0]}), 32'h2);
        rchk(6'h14, 32'h5);
        rchk(6'h10, 32'ha);
        $display("test 5 done");
        repeat (32768) begin
            inc <= 1'b1;
            @(posedge c);
            inc <= 1'b0;
            @(posedge c);
        end
        cyc(2);
        chk(32'(mt), 32'h8000);
        dec <= 1'b1;
        @(posedge c);
        dec <= 1'b0;
        cyc(2);
        chk(32'(mt), 32'h7fff);
        rchk(6'h1c, 32'h7fff);
        $display("test 6 done");
        stop_test;
    end
endmodule
`default_nettype wire
